// ---- common/opc_pkg.sv ----
package opc_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [1:0] OPC_ADDR_LOW = 2'h0;
    localparam logic [1:0] OPC_ADDR_HIGH = 2'h1;
    localparam logic [1:0] OPC_ADDR_RANGE = 2'h2;
    localparam int OPC_ADDR_W = 8;
    localparam int OPC_DATA_W = 16;
    localparam int OPC_WORD_W = 26;
    localparam int OPC_HIGH_W = 10;
    localparam int OPC_OE_BIT = 10;
    localparam int OPC_RANGE_W = 4;
    localparam logic [15:0] OPC_LOW_RST = 16'h0000;
    localparam logic [9:0] OPC_HIGH_RST = 10'h000;
    localparam logic OPC_OE_RST = 1'b0;
    localparam logic [3:0] OPC_RANGE_RST = 4'h0;
    // ---------------------------------------------------------------
    // offset word limits
    // ---------------------------------------------------------------
    localparam logic [25:0] OPC_WORD_RST = 26'h0000000;
    localparam logic [25:0] OPC_WORD_MINUS_EDGE = 26'h2000000;
    localparam logic [25:0] OPC_WORD_NEG_FULL = 26'h2000001;
    // ---------------------------------------------------------------
    // update rate
    // ---------------------------------------------------------------
    localparam int OPC_CLK_HZ = 40_000_000;
    localparam int OPC_UPD_MAX_HZ = 38_000;
    localparam int OPC_UPD_CYCLES = (OPC_CLK_HZ + OPC_UPD_MAX_HZ - 1) / OPC_UPD_MAX_HZ;
    localparam int OPC_GAP_W = 11;
    // ---------------------------------------------------------------
    // pull range table: code -> range in 0.01 ppm, step in 0.1 ppt
    // ---------------------------------------------------------------
    localparam int OPC_CPPM_W = 19;
    localparam int OPC_STEP_W = 10;
    localparam logic [18:0] OPC_RANGE_CPPM [0:15] = '{
        19'd625, 19'd1000, 19'd1250, 19'd2500, 19'd5000, 19'd8000, 19'd10000, 19'd12000,
        19'd15000, 19'd20000, 19'd40000, 19'd60000, 19'd80000, 19'd120000, 19'd160000, 19'd320000};
    localparam logic [9:0] OPC_STEP_DPPT [0:15] = '{
        10'd50, 10'd50, 10'd50, 10'd50, 10'd50, 10'd50, 10'd50, 10'd50,
        10'd50, 10'd50, 10'd100, 10'd140, 10'd210, 10'd320, 10'd470, 10'd940};
    typedef enum logic [1:0] {
        OPC_ST_LOAD = 2'b01,
        OPC_ST_RUN = 2'b10
    } opc_state_t;
endpackage

// ---- hdl/opc_rate_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
module opc_rate_gate
    import opc_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    output logic ready_o
);
    logic [OPC_GAP_W-1:0] cnt_r;
    logic [OPC_GAP_W-1:0] cnt_nxt;

    // reload on each update so the next one waits a full period
    assign cnt_nxt = start_i ? OPC_GAP_W'(OPC_UPD_CYCLES - 1) :
                     (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    assign ready_o = (cnt_r == '0);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/opc_regs.sv ----
// Functional notes
// - power-up at nominal with factory pull range
// - host rewrites range and offset after power-up
// - four-bit field picks sixteen ranges
// - step 5 ppt up to 200 ppm
// - offset is 26-bit two's complement word
// - offset word resets to zero
// - low half 0x00, high half 0x01[9:0]
// - apply new word only on high write
// - word scales linearly, 33554431 is full range
// - never pull beyond selected range
// - software enable bit ignored under pin control
// - updates take effect at most 38 kHz
// - enable bit gates driver, resets off
// - unused upper bits read zero, writes ignored
// - range loads factory value, host may overwrite
`timescale 1ns/1ps
`default_nettype none
module opc_regs
    import opc_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [OPC_ADDR_W-1:0] addr_i,
    input wire logic [OPC_DATA_W-1:0] wdata_i,
    input wire logic [OPC_RANGE_W-1:0] factory_range_i,
    input wire logic oe_sw_ctrl_i,
    input wire logic oe_pin_i,
    output logic [OPC_DATA_W-1:0] rdata_o,
    output logic [OPC_WORD_W-1:0] offset_word_o,
    output logic [OPC_RANGE_W-1:0] range_code_o,
    output logic [OPC_CPPM_W-1:0] range_cppm_o,
    output logic [OPC_STEP_W-1:0] step_dppt_o,
    output logic update_o,
    output logic drive_en_o
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    opc_state_t state_r;
    logic [15:0] low_r;
    logic [OPC_HIGH_W-1:0] high_r;
    logic oe_bit_r;
    logic [OPC_RANGE_W-1:0] range_r;
    logic [OPC_WORD_W-1:0] staged_r;
    logic [OPC_WORD_W-1:0] staged_nxt;
    logic pend_r;
    logic pend_nxt;
    logic [OPC_WORD_W-1:0] applied_r;
    logic [OPC_DATA_W-1:0] rdata_r;
    logic [OPC_DATA_W-1:0] rdata_nxt;
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_s3_r;
    logic pin_lvl_r;
    logic drive_r;
    logic upd_r;
    logic [OPC_CPPM_W-1:0] cppm_r;
    logic [OPC_STEP_W-1:0] step_r;
    logic gate_ready;

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    wire logic loading = (state_r == OPC_ST_LOAD);
    wire logic hit_low = (addr_i == {6'h00, OPC_ADDR_LOW});
    wire logic hit_high = (addr_i == {6'h00, OPC_ADDR_HIGH});
    wire logic hit_range = (addr_i == {6'h00, OPC_ADDR_RANGE});
    wire logic wr_low = wr_en_i && hit_low;
    wire logic wr_high = wr_en_i && hit_high;
    wire logic wr_range = wr_en_i && hit_range && !loading;
    wire logic apply_go = pend_r && gate_ready;
    // low half comes from the register, so a same-word low write must precede
    wire logic [OPC_WORD_W-1:0] new_word = {wdata_i[OPC_HIGH_W-1:0], low_r};
    // the one code beyond -full scale is pulled back
    wire logic [OPC_WORD_W-1:0] clamped =
        (new_word == OPC_WORD_MINUS_EDGE) ? OPC_WORD_NEG_FULL : new_word;
    wire logic drive_nxt = oe_sw_ctrl_i ? oe_bit_r : pin_lvl_r;

    assign staged_nxt = wr_high ? clamped : staged_r;
    // a high write in the apply cycle keeps the flag up
    assign pend_nxt = wr_high ? 1'b1 : (apply_go ? 1'b0 : pend_r);
    assign rdata_nxt = !rd_en_i ? rdata_r :
                       hit_low ? low_r :
                       hit_high ? {5'h00, oe_bit_r, high_r} :
                       hit_range ? {12'h000, range_r} : 16'h0000;

    // ---------------------------------------------------------------
    // update pacing
    // ---------------------------------------------------------------
    opc_rate_gate u_gate (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .start_i(apply_go),
        .ready_o(gate_ready)
    );

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= OPC_ST_LOAD;
            range_r <= OPC_RANGE_RST;
        end else begin
            case (state_r)
                OPC_ST_LOAD: begin
                    range_r <= factory_range_i;
                    state_r <= OPC_ST_RUN;
                end
                OPC_ST_RUN: begin
                    if (wr_range) begin
                        range_r <= wdata_i[OPC_RANGE_W-1:0];
                    end
                end
                default: state_r <= OPC_ST_LOAD;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_r <= OPC_LOW_RST;
            high_r <= OPC_HIGH_RST;
            oe_bit_r <= OPC_OE_RST;
        end else begin
            if (wr_low) begin
                low_r <= wdata_i;
            end
            if (wr_high) begin
                high_r <= wdata_i[OPC_HIGH_W-1:0];
            end
            if (wr_high && oe_sw_ctrl_i) begin
                oe_bit_r <= wdata_i[OPC_OE_BIT];
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            staged_r <= OPC_WORD_RST;
            pend_r <= 1'b0;
            applied_r <= OPC_WORD_RST;
            upd_r <= 1'b0;
        end else begin
            staged_r <= staged_nxt;
            pend_r <= pend_nxt;
            upd_r <= apply_go;
            if (apply_go) begin
                applied_r <= staged_r;
            end
        end
    end

    // table lookups registered so outputs leave from flops
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cppm_r <= '0;
            step_r <= '0;
        end else begin
            cppm_r <= OPC_RANGE_CPPM[range_r];
            step_r <= OPC_STEP_DPPT[range_r];
        end
    end

    // pin level counts only once stages two and three agree
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_s3_r <= 1'b0;
            pin_lvl_r <= 1'b0;
            drive_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            pin_s1_r <= oe_pin_i;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            if (pin_s2_r == pin_s3_r) begin
                pin_lvl_r <= pin_s3_r;
            end
            drive_r <= drive_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign offset_word_o = applied_r;
    assign range_code_o = range_r;
    assign range_cppm_o = cppm_r;
    assign step_dppt_o = step_r;
    assign update_o = upd_r;
    assign drive_en_o = drive_r;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic [OPC_GAP_W-1:0] gap_r;
    logic seen_r;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gap_r <= '0;
            seen_r <= 1'b0;
        end else begin
            seen_r <= seen_r || apply_go;
            gap_r <= apply_go ? OPC_GAP_W'(1) : ((&gap_r) ? gap_r : gap_r + 1'b1);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_high_write_idle;
        wr_high && !pend_r && gate_ready;
    endsequence

    chk_low_holds_word: assert property (!apply_go |=> $stable(applied_r))
        else $error("offset word changed without an update");
    chk_high_applies: assert property (s_high_write_idle |=> ##1 (applied_r == $past(clamped, 2)) && upd_r)
        else $error("high write not applied two cycles later");
    chk_reset_nominal: assert property (loading |-> applied_r == OPC_WORD_RST && low_r == '0 && high_r == '0)
        else $error("offset not zero after reset");
    chk_range_clamp: assert property (applied_r != OPC_WORD_MINUS_EDGE)
        else $error("offset beyond pull range");
    chk_rate_gap: assert property (apply_go && seen_r |-> gap_r >= OPC_GAP_W'(OPC_UPD_CYCLES))
        else $error("updates closer than the rate limit");
    chk_oe_pin_ignore: assert property (!oe_sw_ctrl_i |=> $stable(oe_bit_r))
        else $error("enable bit changed under pin control");
    chk_oe_drive: assert property (oe_sw_ctrl_i && oe_bit_r |=> drive_en_o)
        else $error("driver off while software enable set");
    chk_unused_zero: assert property (rd_en_i && hit_high |=> rdata_o[15:11] == 5'h00)
        else $error("unused high bits read nonzero");
    chk_strap_load: assert property (loading |=> range_r == $past(factory_range_i))
        else $error("factory range not loaded");
endmodule
`default_nettype wire

// ---- test/opc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module opc_host_model (
    input wire logic clk_i,
    output logic wr_en_o,
    output logic rd_en_o,
    output logic [7:0] addr_o,
    output logic [15:0] wdata_o
);
    // idle cycles before each transfer, so a slow host can be modelled
    int gap = 0;
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o = 8'h5a;
        wdata_o = 16'ha5c3;
    end
    // one 16-bit word per transfer; lines scrambled once released
    task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        #2;
        wr_en_o = wr;
        rd_en_o = ~wr;
        addr_o = a;
        wdata_o = d;
        @(posedge clk_i);
        #2;
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    // low half first so the applied word is never mixed
    // enable bit rides along with the high half
    task automatic set_word(input logic [25:0] w, input logic oe);
        access(1'b1, 8'h00, w[15:0]);
        access(1'b1, 8'h01, {5'h00, oe, w[25:16]});
    endtask
endmodule
`default_nettype wire

// ---- test/test_opc_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_opc_regs;
    logic clk_i, resetn_i, wr_en, rd_en, oe_sw, oe_pin, upd, drv;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, v;
    logic [3:0] fact, code;
    logic [25:0] word, w;
    logic [18:0] cppm;
    logic [9:0] step;
    int failures = 0;
    int num_checks = 0;
    int seed = 32'h5c2eabd9;
    int cyc = 0;
    int last_upd = 0;
    int gap = 0;
    int n;
    int c_tbl [16] = '{625, 1000, 1250, 2500, 5000, 8000, 10000, 12000, 15000, 20000, 40000, 60000, 80000,
        120000, 160000, 320000};
    int s_tbl [16] = '{50, 50, 50, 50, 50, 50, 50, 50, 50, 50, 100, 140, 210, 320, 470, 940};

    opc_regs opc_regs_inst (.clk_i(clk_i), .resetn_i(resetn_i), .wr_en_i(wr_en), .rd_en_i(rd_en),
        .addr_i(addr), .wdata_i(wdata), .factory_range_i(fact), .oe_sw_ctrl_i(oe_sw), .oe_pin_i(oe_pin),
        .rdata_o(rdata), .offset_word_o(word), .range_code_o(code), .range_cppm_o(cppm),
        .step_dppt_o(step), .update_o(upd), .drive_en_o(drv));
    opc_host_model opc_host_model_inst (.clk_i(clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
        .wdata_o(wdata));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (upd === 1'b1) begin
            gap <= cyc - last_upd;
            last_upd <= cyc;
        end
    end

    task automatic complete_run;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        opc_host_model_inst.access(1'b0, a, 16'h0000);
        d = rdata;
    endtask
    // bounded wait for the apply pulse
    task automatic wait_upd;
        n = 0;
        while (upd !== 1'b1 && n < 1200) begin
            @(posedge clk_i);
            #2;
            n++;
        end
        if (n >= 1200) begin
            failures++;
            $display("wrong value at %0t: no update pulse within bound", $time);
            complete_run();
        end
    endtask
    function automatic logic [25:0] clamp(input logic [25:0] x);
        return (x == 26'h2000000) ? 26'h2000001 : x;
    endfunction

    initial begin
        resetn_i = 1'b0;
        oe_sw = 1'b0;
        oe_pin = 1'b0;
        fact = 4'h9;
        repeat (16) @(posedge clk_i);
        #2;
        resetn_i = 1'b1;
        repeat (3) @(posedge clk_i);
        #2;
        check(code, 4'h9);
        check(cppm, c_tbl[9]);
        check(word, 26'h0);
        check(drv, 1'b0);
        rd(8'h01, v);
        check(v, 16'h0000);
        rd(8'h02, v);
        check(v, 16'h0009);
        opc_host_model_inst.access(1'b1, 8'h00, 16'h1234);
        repeat (4) @(posedge clk_i);
        #2;
        check(word, 26'h0);
        rd(8'h00, v);
        check(v, 16'h1234);
        // pin control: bit 10 and unused bits must not stick
        opc_host_model_inst.access(1'b1, 8'h01, 16'hffff);
        wait_upd();
        check(word, 26'h3ff1234);
        rd(8'h01, v);
        check(v, 16'h03ff);
        oe_sw = 1'b1;
        opc_host_model_inst.set_word(26'h2000000, 1'b1);
        wait_upd();
        check(word, 26'h2000001);
        repeat (3) @(posedge clk_i);
        #2;
        check(gap, 1053);
        check(upd, 1'b0);
        check(drv, 1'b1);
        oe_sw = 1'b0;
        oe_pin = 1'b1;
        repeat (8) @(posedge clk_i);
        #2;
        check(drv, 1'b1);
        oe_pin = 1'b0;
        repeat (8) @(posedge clk_i);
        #2;
        check(drv, 1'b0);
        for (int i = 0; i < 16; i++) begin
            opc_host_model_inst.access(1'b1, 8'h02, 16'hfff0 | 16'(i));
            repeat (3) @(posedge clk_i);
            #2;
            check(code, i);
            check(cppm, c_tbl[i]);
            check(step, s_tbl[i]);
            rd(8'h02, v);
            check(v, i);
        end
        opc_host_model_inst.access(1'b1, 8'h03, 16'hbeef);
        rd(8'h03, v);
        check(v, 16'h0000);
        rd(8'h00, v);
        check(v, 16'h0000);
        // random words from a slow and a prompt host, sign bit included
        oe_sw = 1'b1;
        for (int k = 0; k < 6; k++) begin
            w = 26'($random(seed));
            opc_host_model_inst.gap = k;
            opc_host_model_inst.set_word(w, k[0]);
            wait_upd();
            check(word, clamp(w));
            repeat (6) @(posedge clk_i);
            #2;
            check(drv, k[0]);
        end
        complete_run();
    end
endmodule
`default_nettype wire
